// File: hw/uhsp_pkg.sv
/*
 * Package for the endpoint byte-stream port: widths, timing counts, handshakes.
 * Assumes one clock shared by both ends of the port.
 */
package uhsp_pkg;
    localparam int          UHSP_DATA_W      = 8;
    localparam int          UHSP_EP_W        = 3;
    localparam int          UHSP_NUM_EP      = 8;
    localparam int          UHSP_REDIR_BIT   = 14;
    localparam int          UHSP_READY_CLKS  = 3;
    localparam int          UHSP_MAX_BULK    = 512;
    localparam int          UHSP_CRC_BYTES   = 2;
    localparam int          UHSP_FIFO_DEPTH  = 32;
    localparam int          UHSP_CLK_MHZ     = 20;
    localparam int          UHSP_HSK_WAIT_NS = 1000;
    localparam int          UHSP_HSK_WAIT_CLKS = (UHSP_HSK_WAIT_NS * UHSP_CLK_MHZ) / 1000;

    typedef enum logic [1:0] {
        UHSP_HSK_ACK   = 2'b00,
        UHSP_HSK_NAK   = 2'b01,
        UHSP_HSK_STALL = 2'b10,
        UHSP_HSK_NONE  = 2'b11
    } uhsp_hsk_t;
endpackage

// File: hw/uhsp_if.sv
/*
 * Interface joining the device end and the user end of the stream port.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/100ps
interface uhsp_if;
    logic       active;
    logic [2:0] xfer_endpoint;
    logic       next;
    logic       error;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    logic       ready;
    logic       halt;

    modport dev (
        output active, xfer_endpoint, next, error, rx_data,
        input  tx_data, ready, halt
    );
    modport user (
        input  active, xfer_endpoint, next, error, rx_data,
        output tx_data, ready, halt
    );
endinterface

// File: hw/uhsp_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/100ps
module uhsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    // Flush drops contents
    input  wire logic             flush
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: hw/uhsp_dev.sv
/*
 * Device end of the endpoint byte-stream port: takes packets from the
 * serial engine for redirected endpoints and plays them on the port.
 * Assumes the serial engine side presents whole packets with a pulse and
 * a handshake result; the user end sits on the interface, same clock.
 */
// How it works
// - Redirect bit 14 routes endpoints 1 to 7 to port; endpoint 0 never
// - Redirect bits may change anytime, many set
// - Everything on one rising clock edge
// - Active high per packet, endpoint held valid
// - Ready within three clocks or NAK
// - Ready low means NAK
// - Halt high means STALL
// - Received bytes one per clock on strobe
// - CRC error shown at fall, drops next clock
// - User drops final two CRC bytes
// - User byte valid clock after strobe
// - User lowers ready after last byte
// - User packets within descriptor maximum
// - Transmit holds active until handshake or timeout
// - User buffers enough; no in-packet flow control
`timescale 1ns/100ps
module uhsp_dev
    import uhsp_pkg::*;
#(
    parameter int MAX_PKT = UHSP_MAX_BULK,
    parameter int HSK_WAIT = UHSP_HSK_WAIT_CLKS
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Endpoint configuration words, bit 14 redirects (ignored for endpoint 0)
    input  wire logic [15:0]      ep_config [UHSP_NUM_EP],
    // Packet request from serial engine
    input  wire logic             pkt_start,
    input  wire logic             pkt_dir_in,
    input  wire logic [2:0]       pkt_ep,
    input  wire logic [9:0]       pkt_len,
    input  wire logic             pkt_crc_bad,
    input  wire logic [7:0]       sie_rx_data,
    // Host handshake after transmit
    input  wire logic             host_ack,
    input  wire logic             host_fail,
    // Results toward serial engine
    output logic                  pkt_to_port,
    output uhsp_hsk_t             pkt_hsk,
    output logic                  pkt_done,
    output logic                  sie_tx_valid,
    output logic [7:0]            sie_tx_data,
    output logic                  sie_rx_take,
    // Port
    uhsp_if.dev                   port
);
    typedef enum logic [2:0] {
        UHSP_IDLE = 3'b000,
        UHSP_WAIT = 3'b001,
        UHSP_RX   = 3'b010,
        UHSP_TX   = 3'b011,
        UHSP_HSK  = 3'b100,
        UHSP_END  = 3'b101
    } uhsp_state_t;

    uhsp_state_t state;
    logic [1:0]  wait_cnt;
    logic [9:0]  byte_cnt;
    logic [15:0] hsk_cnt;
    logic        dir_in;
    logic        crc_bad;
    logic        next_rx;
    logic        next_d;
    logic [UHSP_NUM_EP-1:0] redirected;

    genvar g;
    generate
        for (g = 0; g < UHSP_NUM_EP; g++) begin : g_redir
            // Endpoint 0 stays in the buffers; live bit, no latching
            assign redirected[g] = (g != 0) && ep_config[g][UHSP_REDIR_BIT];
        end
    endgenerate

    // Requests while busy or for buffered endpoints are ignored
    wire take = pkt_start && (state == UHSP_IDLE) && redirected[pkt_ep];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state    <= UHSP_IDLE;
            wait_cnt <= '0;
            byte_cnt <= '0;
            hsk_cnt  <= '0;
            dir_in   <= 1'b0;
            crc_bad  <= 1'b0;
        end else begin
            unique case (state)
                UHSP_IDLE: begin
                    if (take) begin
                        state    <= UHSP_WAIT;
                        dir_in   <= pkt_dir_in;
                        crc_bad  <= pkt_crc_bad;
                        // Oversized requests are cut to the bulk maximum
                        byte_cnt <= (pkt_len > 10'(MAX_PKT)) ? 10'(MAX_PKT) : pkt_len;
                        wait_cnt <= '0;
                    end
                end
                UHSP_WAIT: begin
                    wait_cnt <= wait_cnt + 2'd1;
                    if (port.halt || port.ready) begin
                        state <= port.halt ? UHSP_END : (dir_in ? UHSP_TX : UHSP_RX);
                    end else if (wait_cnt == 2'(UHSP_READY_CLKS - 1)) begin
                        state <= UHSP_END;
                    end
                end
                UHSP_RX: begin
                    // No stall within a packet once ready given
                    if (byte_cnt == '0) begin
                        state <= UHSP_END;
                    end else begin
                        byte_cnt <= byte_cnt - 10'd1;
                    end
                end
                UHSP_TX: begin
                    hsk_cnt <= '0;
                    if (!port.ready) begin
                        state <= UHSP_HSK;
                    end
                end
                UHSP_HSK: begin
                    hsk_cnt <= hsk_cnt + 16'd1;
                    if (host_ack) begin
                        crc_bad <= 1'b0;
                        state   <= UHSP_END;
                    end else if (host_fail || hsk_cnt == 16'(HSK_WAIT - 1)) begin
                        // Host silence counts as a failed handshake
                        crc_bad <= 1'b1;
                        state   <= UHSP_END;
                    end
                end
                UHSP_END: state <= UHSP_IDLE;
                default:  state <= UHSP_IDLE;
            endcase
        end
    end

    // Port outputs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            port.active        <= 1'b0;
            port.error         <= 1'b0;
            port.xfer_endpoint <= '0;
            port.rx_data       <= '0;
        end else begin
            if (take) begin
                port.active        <= 1'b1;
                port.xfer_endpoint <= pkt_ep;
            end else if (state == UHSP_END) begin
                port.active <= 1'b0;
            end
            port.rx_data <= sie_rx_data;
            // Error shows with the fall of active and lasts one clock
            port.error   <= (state == UHSP_END) && crc_bad && !port.error;
        end
    end

    // Strobe: registered for receive; for transmit it follows ready live,
    // so it stops on the very clock on which ready falls
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            next_rx <= 1'b0;
            next_d  <= 1'b0;
        end else begin
            next_rx <= (state == UHSP_RX) && byte_cnt != '0;
            next_d  <= port.next;
        end
    end

    assign port.next = next_rx || ((state == UHSP_TX) && port.ready);

    // Answers to the serial engine
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pkt_to_port  <= 1'b0;
            pkt_hsk      <= UHSP_HSK_NONE;
            pkt_done     <= 1'b0;
            sie_tx_valid <= 1'b0;
            sie_tx_data  <= '0;
            sie_rx_take  <= 1'b0;
        end else begin
            pkt_to_port <= take;
            pkt_done    <= 1'b0;
            if (state == UHSP_WAIT && port.halt) begin
                pkt_hsk  <= UHSP_HSK_STALL;
                pkt_done <= 1'b1;
            end else if (state == UHSP_WAIT && !port.ready
                         && wait_cnt == 2'(UHSP_READY_CLKS - 1)) begin
                pkt_hsk  <= UHSP_HSK_NAK;
                pkt_done <= 1'b1;
            end else if (state == UHSP_END && !pkt_done) begin
                pkt_hsk  <= crc_bad ? UHSP_HSK_NONE : UHSP_HSK_ACK;
                pkt_done <= 1'b1;
            end
            // Transmit byte follows the strobe by two clocks
            sie_tx_valid <= next_d && dir_in;
            sie_tx_data  <= port.tx_data;
            sie_rx_take  <= (state == UHSP_RX) && byte_cnt != '0;
        end
    end
endmodule

// File: hw/uhsp_user.sv
/*
 * User end of the stream port: sinks received packets into a FIFO and
 * sources transmit packets from a FIFO fed by user logic.
 * Assumes the device end on the interface and one clock.
 */
`timescale 1ns/100ps
module uhsp_user
    import uhsp_pkg::*;
#(
    parameter int DEPTH = UHSP_FIFO_DEPTH,
    parameter int TX_LEN = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Static controls
    input  wire logic             user_halt,
    input  wire logic [7:0]       ep_enable,
    // Received payload out
    output logic                  rx_valid,
    input  wire logic             rx_ready,
    output logic [7:0]            rx_data,
    output logic                  rx_good,
    output logic                  rx_bad,
    // Transmit payload in
    input  wire logic             tx_valid,
    output logic                  tx_ready,
    input  wire logic [7:0]       tx_data,
    output logic                  tx_retry,
    // Port
    uhsp_if.user                  port
);
    logic [7:0] hold [UHSP_CRC_BYTES];
    logic [1:0] held;
    logic       act_d;
    logic       rx_pkt;
    logic       rx_in_ready;
    logic       tx_out_valid;
    logic [7:0] tx_out_data;
    logic [9:0] sent;
    logic       ep_ok;

    assign ep_ok = ep_enable[port.xfer_endpoint];

    // Two-byte delay line strips the CRC tail
    wire push = port.next && rx_pkt && held == 2'(UHSP_CRC_BYTES);
    uhsp_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx (
        .clk(clk), .reset_n(reset_n),
        .in_valid(push), .in_ready(rx_in_ready), .in_data(hold[1]),
        .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data),
        .flush(1'b0)
    );
    uhsp_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx (
        .clk(clk), .reset_n(reset_n),
        .in_valid(tx_valid), .in_ready(tx_ready), .in_data(tx_data),
        .out_valid(tx_out_valid), .out_ready(port.next && !rx_pkt),
        .out_data(tx_out_data), .flush(1'b0)
    );

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            act_d  <= 1'b0;
            rx_pkt <= 1'b0;
            held   <= '0;
            hold[0] <= '0;
            hold[1] <= '0;
            rx_good <= 1'b0;
            rx_bad  <= 1'b0;
            tx_retry <= 1'b0;
            sent   <= '0;
            port.ready <= 1'b0;
            port.halt  <= 1'b0;
            port.tx_data <= '0;
        end else begin
            act_d <= port.active;
            port.halt <= user_halt;
            rx_good <= 1'b0;
            rx_bad  <= 1'b0;
            tx_retry <= 1'b0;
            if (port.active && !act_d) begin
                // Receive needs FIFO room, transmit needs data
                rx_pkt <= !tx_out_valid;
                held   <= '0;
                sent   <= '0;
                port.ready <= ep_ok && (tx_out_valid || rx_in_ready);
            end
            if (port.next && rx_pkt) begin
                hold[0] <= port.rx_data;
                hold[1] <= hold[0];
                if (held != 2'(UHSP_CRC_BYTES)) held <= held + 2'd1;
            end
            if (port.next && !rx_pkt) begin
                sent <= sent + 10'd1;
                port.tx_data <= tx_out_data;
                if (sent + 10'd1 >= 10'(TX_LEN) || !tx_out_valid) begin
                    port.ready <= 1'b0;
                end
            end
            if (!port.active && act_d) begin
                port.ready <= 1'b0;
                if (rx_pkt) begin
                    rx_bad  <= port.error;
                    rx_good <= !port.error;
                end else begin
                    tx_retry <= port.error;
                end
            end
        end
    end
endmodule

// File: test/uhsp_checker.sv
/*
 * Checker on the stream port wires between the two ends.
 * Assumes one clock and synchronous active-low reset.
 */
`timescale 1ns/100ps
module uhsp_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // Port wires
    input wire logic       active,
    input wire logic [2:0] xfer_endpoint,
    input wire logic       next,
    input wire logic       error,
    input wire logic       ready,
    input wire logic       halt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_reset_quiet: assert property (disable iff (1'b0)
        !reset_n |=> !active && !next && !error) else $error("port busy after reset");
    a_ep_steady: assert property (
        active && $past(active) |-> $stable(xfer_endpoint)) else $error("endpoint moved");
    a_next_gated: assert property (
        next |-> active && ready) else $error("byte outside ready transfer");
    a_error_pulse: assert property (
        error |=> !error) else $error("error longer than one clock");
    a_error_at_fall: assert property (
        error |-> !active && $past(active)) else $error("error away from fall");
    a_halt_no_data: assert property (
        halt && active |-> !next) else $error("bytes while halted");
    a_ready_first: assert property (
        $rose(active) |-> !next ##1 !next) else $error("byte before ready window");
    a_active_bound: assert property (
        $rose(active) |-> ##[1:600] !active) else $error("transfer never ends");
endmodule

// File: test/test_usb_endpoint_hw_stream_port.sv
/*
 * Bench for both ends of the stream port, joined by the interface.
 * Assumes the design package; inputs change on the falling edge.
 */
`timescale 1ns/100ps
module test_usb_endpoint_hw_stream_port;
    import uhsp_pkg::*;
    localparam int TXL = 4;
    logic        clk, reset_n, pkt_start, pkt_dir_in, pkt_crc_bad, host_ack, host_fail;
    logic        pkt_to_port, pkt_done, sie_tx_valid, sie_rx_take, rx_valid, rx_good;
    logic        rx_bad, tx_ready, tx_retry, user_halt, rx_ready, tx_valid, done;
    logic        to_port;
    logic [2:0]  pkt_ep;
    logic [9:0]  pkt_len;
    logic [7:0]  ep_enable, tx_data, rx_data, sie_tx_data, rx_idx, base;
    logic [15:0] ep_config [UHSP_NUM_EP];
    uhsp_hsk_t   pkt_hsk, hsk;
    int          error_cnt, comparisons, cnt [4];
    logic [7:0]  rxq [$], txq [$];
    wire  [7:0]  sie_rx_data = 8'hA0 + rx_idx;

    uhsp_if port ();
    uhsp_dev #(.HSK_WAIT(8)) uhsp_dev_inst (
        .clk, .reset_n, .ep_config, .pkt_start, .pkt_dir_in, .pkt_ep, .pkt_len,
        .pkt_crc_bad, .sie_rx_data, .host_ack, .host_fail, .pkt_to_port, .pkt_hsk,
        .pkt_done, .sie_tx_valid, .sie_tx_data, .sie_rx_take, .port(port));
    uhsp_user #(.TX_LEN(TXL)) uhsp_user_inst (
        .clk, .reset_n, .user_halt, .ep_enable, .rx_valid, .rx_ready, .rx_data,
        .rx_good, .rx_bad, .tx_valid, .tx_ready, .tx_data, .tx_retry, .port(port));
    uhsp_checker uhsp_checker_inst (
        .clk, .reset_n, .active(port.active), .xfer_endpoint(port.xfer_endpoint),
        .next(port.next), .error(port.error), .ready(port.ready), .halt(port.halt));

    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    // Counts error, good, bad and retry pulses, so a doubled one shows up as a wrong count
    always @(posedge clk) begin
        if (pkt_done) begin
            done <= 1;
            hsk <= pkt_hsk;
        end
        if (pkt_to_port) to_port <= 1;
        if (port.error) cnt[0]++;
        if (rx_good) cnt[1]++;
        if (rx_bad) cnt[2]++;
        if (tx_retry) cnt[3]++;
        if (rx_valid && rx_ready) rxq.push_back(rx_data);
        if (sie_tx_valid) txq.push_back(sie_tx_data);
    end
    // Serial side byte source advances only past taken bytes
    always @(negedge clk) if (sie_rx_take) rx_idx <= rx_idx + 8'h01;

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            error_cnt++;
            $display("BAD t=%0t count %0d want %0d", $time, got, exp);
        end
    endtask
    task automatic note(input string s);
        $display("test %s ends, %0d mismatches", s, error_cnt);
    endtask
    task automatic end_sim;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic pkt(input logic din, input logic [2:0] ep, input logic [9:0] len,
                       input logic bad, input logic ok);
        logic hs;
        hs = 0;
        @(negedge clk);
        {done, to_port} = '0;
        cnt = '{4{0}};
        rxq = {};
        txq = {};
        base = rx_idx;
        {pkt_start, pkt_dir_in, pkt_ep, pkt_len, pkt_crc_bad} = {1'b1, din, ep, len, bad};
        @(negedge clk);
        pkt_start = 0;
        // Host answers once, only after the whole packet went out
        for (int n = 0; n < 300 && !done; n++) begin
            host_ack = !hs && din && ok && txq.size() == TXL;
            host_fail = !hs && din && !ok && txq.size() == TXL;
            hs = hs || host_ack || host_fail;
            @(negedge clk);
        end
        {host_ack, host_fail} = '0;
        repeat (40) @(negedge clk);
    endtask
    task automatic load(input logic [7:0] v0);
        for (int i = 0; i < TXL; i++) begin
            @(negedge clk);
            tx_valid = 1;
            tx_data = v0 + 8'(i);
            @(posedge clk);
            while (!tx_ready) @(posedge clk);
        end
        @(negedge clk);
        tx_valid = 0;
    endtask

    initial begin
        {reset_n, pkt_start, pkt_dir_in, pkt_crc_bad, host_ack, host_fail} = '0;
        {user_halt, tx_valid, done, to_port, pkt_ep, pkt_len, tx_data, rx_idx} = '0;
        {ep_enable, rx_ready} = {8'hFF, 1'b1};
        foreach (ep_config[i]) ep_config[i] = (i == 1 || i == 4) ? 16'h4000 : 16'h0000;
        repeat (8) @(negedge clk);
        reset_n = 1;
        pkt(0, 3'h1, 10'h00A, 0, 1);
        chk8(8'(hsk), 8'(UHSP_HSK_ACK));
        chkn(rxq.size(), 8);
        foreach (rxq[i]) chk8(rxq[i], 8'hA0 + base + 8'(i));
        chkn(cnt[1], 1);
        note("rx");
        pkt(0, 3'h4, 10'h006, 1, 1);
        chkn(cnt[0], 1);
        chkn(cnt[2], 1);
        note("crc");
        for (int k = 0; k < 3; k++) begin
            // Third pass resends the bytes of the failed second packet, whose retry is flagged
            load(8'h50 + 8'(k * 16 - (k / 2) * 16));
            pkt(1, 3'h4, 10'h000, 0, k != 1);
            chkn(txq.size(), TXL);
            chk8(8'(hsk), 8'(k == 1 ? UHSP_HSK_NONE : UHSP_HSK_ACK));
            foreach (txq[i]) chk8(txq[i], 8'h50 + 8'(k * 16 - (k / 2) * 16 + i));
            chkn(cnt[0], k == 1);
            chkn(cnt[3], k == 1);
        end
        note("tx");
        ep_enable = 8'hFD;
        pkt(0, 3'h1, 10'h00A, 0, 1);
        chk8(8'(hsk), 8'(UHSP_HSK_NAK));
        chkn(rxq.size(), 0);
        {ep_enable, user_halt} = {8'hFF, 1'b1};
        pkt(0, 3'h4, 10'h00A, 0, 1);
        chk8(8'(hsk), 8'(UHSP_HSK_STALL));
        user_halt = 0;
        note("nak stall");
        {ep_config[4], ep_config[2]} = {16'h0000, 16'h4000};
        pkt(0, 3'h4, 10'h00A, 0, 1);
        chk8({7'h00, to_port}, 8'h00);
        pkt(0, 3'h2, 10'h00A, 0, 1);
        chk8(8'(hsk), 8'(UHSP_HSK_ACK));
        note("redirect");
        rx_ready = 0;
        pkt(0, 3'h1, 10'h022, 0, 1);
        chk8({7'h00, rx_valid}, 8'h01);
        rx_ready = 1;
        repeat (40) @(negedge clk);
        chkn(rxq.size(), 32);
        chk8(rxq[31], 8'hA0 + base + 8'h1F);
        chk8({7'h00, rx_valid}, 8'h00);
        note("fifo");
        end_sim();
    end
    // About 1000 clocks of tests; far more means a hang
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("BAD t=%0t watchdog", $time);
        end_sim();
    end
endmodule
